//--- logic/twr_bank.sv
// Function
// - Each wide register is reached as two separate byte transfers.
// - One 8-bit high-byte latch serves all wide registers.
// - Writing a high-byte location only loads the latch.
// - Low-byte write loads latch and low byte into register together.
// - Count or capture low-byte read copies the upper half into the latch same cycle.
// - Compare reads bypass the latch and leave it undisturbed.
// - Capture high-byte read returns the latch contents.
// - Latch keeps its value after a low-byte write.
//
// Top of the wide register byte access bank: count, two compare values
// and capture, each 16 bits, reached byte by byte through one latch.
// Assumes a single-cycle 8-bit bus from the processor core on clk; timer
// logic supplies count and capture updates, processor writes win.
// Assumes the processor keeps its byte order and never lets another
// access land between the two halves of a pair.
`timescale 1ns/1ps
module twr_bank
    import twr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic count_load,
    input wire logic [15:0] count_load_value,
    input wire logic capture_load,
    input wire logic [15:0] capture_load_value,
    output logic [15:0] timer_count_value,
    output logic [15:0] compare_a_value,
    output logic [15:0] compare_b_value,
    output logic [15:0] capture_value
);
    // Storage: one flip-flop word per wide register, picked by index
    logic [15:0] wide_reg [4];
    logic [15:0] wide_next [4];
    // Registered read byte; it holds between reads
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    // Decode of the byte location and of the strobe that comes with it
    logic [1:0] idx;
    logic is_hi;
    logic backed;
    logic wr_hi;
    logic wr_lo;
    logic rd_hi;
    logic rd_lo;
    // Commit strobe per wide register from a processor low-byte write
    logic [3:0] cpu_commit;
    // Byte a read returns, before it is registered
    logic [7:0] rd_lo_byte;
    logic [7:0] rd_hi_byte;

    // The shared latch sits in a module of its own, so no wide register
    // can quietly grow a private upper-byte copy. Only one access pair
    // may be in flight: a second pair other than a compare read between
    // the halves of the first overwrites the latch and corrupts the first pair's value.
    twr_latch_if lif ();

    twr_latch u_latch (
        .clk (clk),
        .nrst (nrst),
        .lif (lif)
    );

    // Which wide register a byte location refers to
    function automatic logic [1:0] reg_index(input logic [2:0] a);
        reg_index = a[2:1];
    endfunction : reg_index

    // Odd byte locations hold the upper half
    function automatic logic byte_is_high(input logic [2:0] a);
        byte_is_high = a[0];
    endfunction : byte_is_high

    // Count and capture reads go through the latch; compare reads do not
    function automatic logic uses_latch(input logic [1:0] i);
        uses_latch = (i == IDX_CNT) || (i == IDX_CAP);
    endfunction : uses_latch

    // Halves of a wide word
    function automatic logic [7:0] upper_half(input logic [15:0] w);
        upper_half = w[15:8];
    endfunction : upper_half

    function automatic logic [7:0] lower_half(input logic [15:0] w);
        lower_half = w[7:0];
    endfunction : lower_half

    // A committed word is the latch on top of the byte just written
    function automatic logic [15:0] commit_word(input logic [7:0] hi,
        input logic [7:0] lo);
        commit_word = {hi, lo};
    endfunction : commit_word

    // Location and strobe decode; a read and a write in one cycle is not
    // supported, at a high location the write side would win on the latch
    assign idx = reg_index(bus_addr);
    assign is_hi = byte_is_high(bus_addr);
    assign backed = uses_latch(idx);
    assign wr_hi = bus_wr && is_hi;
    assign wr_lo = bus_wr && !is_hi;
    assign rd_hi = bus_rd && is_hi;
    assign rd_lo = bus_rd && !is_hi;

    // Latch strobes; every high write goes to the latch, but only reads
    // of count and capture refill it, so compare reads leave it alone
    always_comb
    begin
        lif.load_wr = wr_hi;
        lif.wr_value = bus_wdata;
        lif.load_rd = rd_lo && backed;
        lif.rd_value = upper_half(wide_reg[idx]);
    end

    // One commit strobe per register from a low-byte write; a high write
    // raises none of them, so it can never alter a wide word
    always_comb
    begin
        cpu_commit = 4'h0;
        if (wr_lo)
            cpu_commit[idx] = 1'b1;
    end

    // Wide register next values; a low-byte write commits latch and byte
    // together and leaves the latch as it was for the next low write.
    // A processor write has priority over a timer load of the same word;
    // the timer value is dropped, never merged byte by byte
    always_comb
    begin
        // Count: processor low write, else timer load, else hold
        if (cpu_commit[IDX_CNT])
            wide_next[IDX_CNT] = commit_word(lif.value, bus_wdata);
        else if (count_load)
            wide_next[IDX_CNT] = count_load_value;
        else
            wide_next[IDX_CNT] = wide_reg[IDX_CNT];

        // Compare A: only the processor writes it
        if (cpu_commit[IDX_CMPA])
            wide_next[IDX_CMPA] = commit_word(lif.value, bus_wdata);
        else
            wide_next[IDX_CMPA] = wide_reg[IDX_CMPA];

        // Compare B: only the processor writes it
        if (cpu_commit[IDX_CMPB])
            wide_next[IDX_CMPB] = commit_word(lif.value, bus_wdata);
        else
            wide_next[IDX_CMPB] = wide_reg[IDX_CMPB];

        // Capture: processor low write, else timer load, else hold
        if (cpu_commit[IDX_CAP])
            wide_next[IDX_CAP] = commit_word(lif.value, bus_wdata);
        else if (capture_load)
            wide_next[IDX_CAP] = capture_load_value;
        else
            wide_next[IDX_CAP] = wide_reg[IDX_CAP];
    end

    // Wide registers only take their next values
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wide_reg[IDX_CNT] <= WIDE_RST;
            wide_reg[IDX_CMPA] <= WIDE_RST;
            wide_reg[IDX_CMPB] <= WIDE_RST;
            wide_reg[IDX_CAP] <= WIDE_RST;
        end
        else
        begin
            wide_reg[IDX_CNT] <= wide_next[IDX_CNT];
            wide_reg[IDX_CMPA] <= wide_next[IDX_CMPA];
            wide_reg[IDX_CMPB] <= wide_next[IDX_CMPB];
            wide_reg[IDX_CAP] <= wide_next[IDX_CAP];
        end
    end

    // Low half comes straight from the addressed word
    assign rd_lo_byte = lower_half(wide_reg[idx]);

    // Upper half: the latch for count and capture, the live word for
    // compares; a high read with no low read before it returns whatever
    // the latch last held
    always_comb
    begin
        if (backed)
            rd_hi_byte = lif.value;
        else
            rd_hi_byte = upper_half(wide_reg[idx]);
    end

    // Read data next value; it changes only on a read strobe, so a timer
    // load between the halves of a read does not tear the pair
    always_comb
    begin
        rdata_next = rdata_reg;
        if (rd_lo)
            rdata_next = rd_lo_byte;
        else if (rd_hi)
            rdata_next = rd_hi_byte;
    end

    // Read data register only takes its next value
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata_reg <= RDATA_RST;
        else
            rdata_reg <= rdata_next;
    end

    // Every output comes straight from a flip-flop, so the timer side
    // never sees decode glitches
    assign bus_rdata = rdata_reg;
    assign timer_count_value = wide_reg[IDX_CNT];
    assign compare_a_value = wide_reg[IDX_CMPA];
    assign compare_b_value = wide_reg[IDX_CMPB];
    assign capture_value = wide_reg[IDX_CAP];
endmodule : twr_bank

//--- logic/twr_pkg.sv
// Package for the wide timer register byte access block.
// Assumes an 8-bit processor bus with byte locations numbered as below.
package twr_pkg;
    // Byte location offsets on the 8-bit I/O bus
    localparam logic [2:0] CNT_LO_OFS = 3'h0;
    localparam logic [2:0] CNT_HI_OFS = 3'h1;
    localparam logic [2:0] CMPA_LO_OFS = 3'h2;
    localparam logic [2:0] CMPA_HI_OFS = 3'h3;
    localparam logic [2:0] CMPB_LO_OFS = 3'h4;
    localparam logic [2:0] CMPB_HI_OFS = 3'h5;
    localparam logic [2:0] CAP_LO_OFS = 3'h6;
    localparam logic [2:0] CAP_HI_OFS = 3'h7;
    // Register index within the bank
    localparam logic [1:0] IDX_CNT = 2'h0;
    localparam logic [1:0] IDX_CMPA = 2'h1;
    localparam logic [1:0] IDX_CMPB = 2'h2;
    localparam logic [1:0] IDX_CAP = 2'h3;
    // Values after reset
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [15:0] WIDE_RST = 16'h0000;
    localparam logic [7:0] RDATA_RST = 8'h00;
endpackage : twr_pkg

//--- logic/twr_if.sv
// Interface carrying the shared high-byte latch controls.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface twr_latch_if;
    logic load_wr;
    logic [7:0] wr_value;
    logic load_rd;
    logic [7:0] rd_value;
    logic [7:0] value;
    modport owner (input load_wr, input wr_value, input load_rd,
        input rd_value, output value);
    modport user (output load_wr, output wr_value, output load_rd,
        output rd_value, input value);
endinterface : twr_latch_if

//--- logic/twr_latch.sv
// Shared 8-bit high-byte latch serving every wide register of the timer.
// Assumes at most one of the two load strobes is high in any cycle.
`timescale 1ns/1ps
module twr_latch
    import twr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    twr_latch_if.owner lif
);
    logic [7:0] latch_reg;
    logic [7:0] latch_next;

    // One latch for all wide registers; holds unless strobed
    always_comb
    begin
        latch_next = latch_reg;
        if (lif.load_wr)
            latch_next = lif.wr_value;
        else if (lif.load_rd)
            latch_next = lif.rd_value;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            latch_reg <= LATCH_RST;
        else
            latch_reg <= latch_next;
    end

    assign lif.value = latch_reg;
endmodule : twr_latch

//--- bench/twr_checker.sv
// Checker for the byte access bank, bound to its ports.
// Assumes one clock and the byte map of the package.
`timescale 1ns/1ps
module twr_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic [15:0] timer_count_value,
    input wire logic [15:0] compare_a_value
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Strobe and address packed so each event is one compare
    logic [3:0] wa, ra;
    assign wa = {bus_wr, bus_addr};
    assign ra = {bus_rd, bus_addr};
    hi_wr_keep_a: assert property (wa == 4'hb |=>
        $stable(compare_a_value)) else $error("high write moved value");
    lo_wr_load_a: assert property (wa == 4'h8 |=>
        timer_count_value[7:0] == $past(bus_wdata)) else $error("low write");
    cmp_hi_rd_a: assert property (ra == 4'hb |=>
        bus_rdata == $past(compare_a_value[15:8])) else $error("cmp read");
    lo_rd_copy_a: assert property (ra == 4'h8 ##1 ra == 4'h9 |=>
        bus_rdata == $past(timer_count_value[15:8], 2)) else $error("latch");
    lo_rd_data_a: assert property (ra == 4'h8 |=>
        bus_rdata == $past(timer_count_value[7:0])) else $error("low read");
    shared_hi_a: assert property (wa == 4'h9 ##1 wa == 4'h8
        ##1 wa == 4'ha |=>
        compare_a_value == {$past(bus_wdata, 3), $past(bus_wdata)})
        else $error("shared latch");
    cmp_skip_a: assert property (ra == 4'h8 ##1 ra == 4'hc
        ##1 ra == 4'h9 |=>
        bus_rdata == $past(timer_count_value[15:8], 3))
        else $error("cmp read hit latch");
    rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
        else $error("read data moved");
endmodule : twr_checker
bind twr_bank twr_checker chk_i (.clk, .nrst, .bus_addr, .bus_wr, .bus_rd,
    .bus_wdata, .bus_rdata, .timer_count_value, .compare_a_value);

//--- bench/twr_cpu.sv
// Processor core model: one byte transfer a cycle, {wr, rd, addr, data}.
// Assumes calls start just after a rising edge of clk.
`timescale 1ns/1ps
module twr_cpu (
    input wire logic clk,
    output logic [12:0] bus,
    input wire logic [7:0] bus_rdata
);
    logic [7:0] q;
    initial bus = '0;
    // Read data of the previous transfer is taken before driving anew
    task op(input logic [12:0] b);
        #1 q = bus_rdata;
        bus = b;
        @(posedge clk);
    endtask : op
    // Released bus shows inverted leftovers, never a stale match
    task idle;
        op({2'b00, ~bus[10:0]});
    endtask : idle
    // Pairs never interleave, so nothing disturbs the latch mid-pair
    task w16(input logic [1:0] i, input logic [15:0] v);
        op({2'b10, i, 1'b1, v[15:8]});
        op({2'b10, i, 1'b0, v[7:0]});
        idle;
    endtask : w16
    task r16(input logic [1:0] i, output logic [15:0] v);
        op({2'b01, i, 9'h000});
        op({2'b01, i, 9'h100});
        v[7:0] = q;
        idle;
        v[15:8] = q;
    endtask : r16
endmodule : twr_cpu

//--- bench/tb_twr_bank.sv
// Random and corner tests of the wide register byte access bank.
// Assumes the twr_cpu model drives the byte bus.
`timescale 1ns/1ps
module tb_twr_bank;
    import twr_pkg::*;
    logic clk = 0, nrst = 0, ld = 0;
    logic [15:0] cv = 0, v, t, c[4];
    logic [12:0] b;
    logic [7:0] rd;
    int n_fail = 0, checks_done = 0;
    twr_bank uut (.clk, .nrst, .bus_addr(b[10:8]), .bus_wr(b[12]),
        .bus_rd(b[11]), .bus_wdata(b[7:0]), .bus_rdata(rd),
        .count_load(ld), .count_load_value(cv), .capture_load(ld),
        .capture_load_value(~cv), .timer_count_value(c[0]),
        .compare_a_value(c[1]), .compare_b_value(c[2]),
        .capture_value(c[3]));
    twr_cpu cpu (.clk, .bus(b), .bus_rdata(rd));
    // Expected wide word from the byte pair software wrote
    function automatic logic [15:0] pair16(input logic [7:0] h, l);
        pair16 = {h, l};
    endfunction : pair16
    task chk(input logic [15:0] s, e, input string n);
        checks_done++;
        if (s !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    initial forever #20 clk = ~clk;
    // Run needs some 160 cycles; 2000 means a hang
    initial
    begin
        #80000 n_fail++;
        complete_run;
    end
    initial
    begin
        void'($urandom(32'h73573900));
        repeat (2) @(posedge clk);
        #1 nrst = 1;
        chk(c[0], WIDE_RST, "reset");
        @(posedge clk);
        // Random round trips through every register
        repeat (6) for (int i = 0; i < 4; i++)
        begin
            v = 16'($urandom);
            cpu.w16(i[1:0], v);
            chk(c[i], v, "wide");
            cpu.r16(i[1:0], t);
            chk(t, v, "read");
        end
        // Compare B upper differs from count upper, so a stray refill shows
        cpu.w16(2'h2, ~v);
        // One high write serves two low writes
        cpu.op({5'h11, v[15:8]});
        cpu.op({5'h10, t[7:0]});
        cpu.op({5'h12, ~t[7:0]});
        // Compare low read between count halves
        cpu.op({5'h08, 8'h00});
        cpu.op({5'h0c, 8'h00});
        cpu.op({5'h09, 8'h00});
        cpu.idle;
        chk(c[2], ~v, "compare b");
        chk(c[0], pair16(v[15:8], t[7:0]), "shared count");
        chk(c[1], pair16(v[15:8], ~t[7:0]), "shared");
        chk({8'h00, cpu.q}, {8'h00, v[15:8]}, "skip");
        // Timer reloads capture between the halves of a read
        t = c[3];
        cpu.op({5'h0e, 8'h00});
        fork
            cpu.idle;
            begin
                #1 ld = 1;
                cv = 16'($urandom);
            end
        join
        fork
            cpu.op({5'h0f, 8'h00});
            #1 ld = 0;
        join
        cpu.idle;
        chk({8'h00, cpu.q}, {8'h00, t[15:8]}, "latch");
        chk(c[0], cv, "count");
        chk(c[3], ~cv, "capture");
        complete_run;
    end
endmodule : tb_twr_bank
